// ==== verilog/scr_pkg.sv ====
// Purpose: constants and types for the sync and clock control register group
// Assumes: byte-wide register port, byte addresses as used by the serial port
// Notes: the 24-bit capture status spans three byte addresses, low byte first
package scr_pkg;

	localparam int SCR_ADDR_W = 15;
	typedef logic [SCR_ADDR_W-1:0] scr_addr_t;
	typedef logic [7:0] scr_byte_t;

	// register byte addresses
	localparam scr_addr_t SCR_OFF_CLOCK_CONTROL_0 = 15'h0029;
	localparam scr_addr_t SCR_OFF_CLOCK_CONTROL_1 = 15'h002a;
	localparam scr_addr_t SCR_OFF_CLOCK_CONTROL_2 = 15'h002b;
	localparam scr_addr_t SCR_OFF_CAPTURE_POS_B0 = 15'h002c;
	localparam scr_addr_t SCR_OFF_CAPTURE_POS_B1 = 15'h002d;
	localparam scr_addr_t SCR_OFF_CAPTURE_POS_B2 = 15'h002e;

	// values after reset
	localparam scr_byte_t SCR_RST_CLOCK_CONTROL_0 = 8'h80;
	localparam scr_byte_t SCR_RST_CLOCK_CONTROL_1 = 8'h00;
	localparam scr_byte_t SCR_RST_CLOCK_CONTROL_2 = 8'h10;
	localparam logic [23:0] SCR_RST_CAPTURE_POS = 24'h000000;
	localparam scr_byte_t SCR_RDATA_UNMAPPED = 8'h00;

	// clock_control_0 fields
	localparam int SCR_BIT_PROCESSOR_EN = 6;
	localparam int SCR_BIT_RECEIVER_EN = 5;
	localparam int SCR_BIT_FINE_STEP = 4;
	localparam int SCR_SEL_LSB = 0;
	localparam int SCR_SEL_W = 4;
	// clock_control_1 fields
	localparam int SCR_BIT_CLOCK_PECL = 2;
	localparam int SCR_BIT_SYNC_PECL = 1;
	localparam int SCR_BIT_POL_INVERT = 0;
	// clock_control_2 fields
	localparam int SCR_BIT_ANALOG_QUIET = 2;
	localparam int SCR_BIT_CLOCK_QUIET = 0;

	localparam int SCR_POS_W = 24;

	typedef struct packed {
		scr_byte_t value;
	} scr_byte_state_t;

	typedef struct packed {
		logic [SCR_POS_W-1:0] pos;
		scr_byte_t rdata;
		logic rd_valid;
	} scr_main_state_t;

endpackage

// ==== verilog/scr_reg_if.sv ====
// Purpose: carries write strobe, write data and held value of one byte register
// Assumes: one instance per register
// Notes: owner holds the flop, user drives the strobe
interface scr_reg_if;
	logic wr_en;
	logic [7:0] wdata;
	logic [7:0] q;
	modport owner (input wr_en, input wdata, output q);
	modport user (output wr_en, output wdata, input q);
endinterface

// ==== verilog/scr_byte_reg.sv ====
// Purpose: one read/write byte register with a fixed value after reset
// Assumes: synchronous reset wins over clock enable
// Notes: every bit, reserved ones included, stores what is written
module scr_byte_reg #(
	parameter logic [7:0] RESET_VALUE = 8'h00
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	scr_reg_if.owner port
);
	import scr_pkg::*;

	scr_byte_state_t st;
	scr_byte_state_t next_st;

	always_comb begin
		next_st = st;
		if (port.wr_en) begin
			next_st.value = port.wdata;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st.value <= RESET_VALUE;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign port.q = st.value;

	a_byte_write_lands: assert property (@(posedge i_core_clk) disable iff (i_rst)
		i_ce && port.wr_en |=> port.q == $past(port.wdata))
		else $error("byte register missed a write");

	a_byte_reset_value: assert property (@(posedge i_core_clk)
		$past(i_rst) |-> port.q == RESET_VALUE)
		else $error("byte register wrong after reset");

endmodule

// ==== verilog/scr_clock_control_regs.sv ====
// Purpose: sync input and clock input control registers plus capture status
// Assumes: register port is byte wide and synchronous to i_core_clk
// Notes: reads answer one cycle later on o_rd_valid; writes land at the edge
// How it works
// [RULE1] software writes reserved bits with their defaults (ones in byte 0 top and byte 2 bit 4)
// [RULE2] clock_control_0 bit 6 enables the sync processor; resets to zero
// [RULE3] software enables the receiver no later than the processor
// [RULE4] clock_control_0 bit 5 enables the sync receiver; resets to zero
// [RULE5] clock_control_0 bit 4 selects fine window delay steps
// [RULE6] software turns fine steps on at high clock rates
// [RULE7] clock_control_0 bits 3:0 select the sync delay tap; reset zero
// [RULE8] software picks the delay tap after reading capture status
// [RULE9] clock_control_1 bit 0 inverts sync polarity; resets to zero
// [RULE10] clock_control_1 bit 2 selects PECL mode for sampling clock input
// [RULE11] clock_control_1 bit 1 selects PECL mode for sync input
// [RULE12] clock_control_2 bit 2 enables analog supply noise suppression
// [RULE13] clock_control_2 bit 0 enables clock supply noise suppression
// [RULE14] clock_control_0 reads 0x80 after reset
// [RULE15] clock_control_1 reads 0x00 after reset
// [RULE16] clock_control_2 reads 0x10 after reset, suppression off
// [RULE17] capture position at 0x2c is read-only detector status
// [RULE18] capture position is 24 bits, one indication per delay setting
// [RULE19] writes to capture position are ignored and disturb nothing
module scr_clock_control_regs (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	input wire scr_pkg::scr_addr_t i_addr,
	input wire scr_pkg::scr_byte_t i_wdata,
	input wire logic i_pos_valid,
	input wire logic [23:0] i_pos_status,
	output logic [7:0] o_rdata,
	output logic o_rd_valid,
	output logic o_sync_processor_enable,
	output logic o_sync_receiver_enable,
	output logic o_window_fine_step,
	output logic [3:0] o_sync_delay_select,
	output logic o_sync_polarity_invert,
	output logic o_clock_input_pecl_mode,
	output logic o_sync_input_pecl_mode,
	output logic o_analog_supply_quiet_enable,
	output logic o_clock_supply_quiet_enable
);
	import scr_pkg::*;

	scr_main_state_t st;
	scr_main_state_t next_st;

	scr_reg_if ctl0 ();
	scr_reg_if ctl1 ();
	scr_reg_if ctl2 ();

	logic hit_ctl0;
	logic hit_ctl1;
	logic hit_ctl2;
	logic hit_pos;

	assign hit_ctl0 = (i_addr == SCR_OFF_CLOCK_CONTROL_0);
	assign hit_ctl1 = (i_addr == SCR_OFF_CLOCK_CONTROL_1);
	assign hit_ctl2 = (i_addr == SCR_OFF_CLOCK_CONTROL_2);
	assign hit_pos = (i_addr == SCR_OFF_CAPTURE_POS_B0) || (i_addr == SCR_OFF_CAPTURE_POS_B1) ||
		(i_addr == SCR_OFF_CAPTURE_POS_B2);

	// only the three control bytes take writes; status addresses have no strobe
	assign ctl0.wr_en = i_wr_en && hit_ctl0;
	assign ctl1.wr_en = i_wr_en && hit_ctl1;
	assign ctl2.wr_en = i_wr_en && hit_ctl2;
	assign ctl0.wdata = i_wdata;
	assign ctl1.wdata = i_wdata;
	assign ctl2.wdata = i_wdata;

	scr_byte_reg #(.RESET_VALUE(SCR_RST_CLOCK_CONTROL_0)) u_ctl0 ( // [RULE14]
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.port(ctl0.owner)
	);

	scr_byte_reg #(.RESET_VALUE(SCR_RST_CLOCK_CONTROL_1)) u_ctl1 ( // [RULE15]
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.port(ctl1.owner)
	);

	scr_byte_reg #(.RESET_VALUE(SCR_RST_CLOCK_CONTROL_2)) u_ctl2 ( // [RULE16]
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.port(ctl2.owner)
	);

	// read multiplexer; a read in the same cycle as a write sees the old value
	function automatic scr_byte_t read_mux(input scr_addr_t addr, input scr_byte_t c0,
		input scr_byte_t c1, input scr_byte_t c2, input logic [23:0] pos);
		scr_byte_t r;
		r = SCR_RDATA_UNMAPPED;
		if (addr == SCR_OFF_CLOCK_CONTROL_0) begin
			r = c0;
		end else if (addr == SCR_OFF_CLOCK_CONTROL_1) begin
			r = c1;
		end else if (addr == SCR_OFF_CLOCK_CONTROL_2) begin
			r = c2;
		end else if (addr == SCR_OFF_CAPTURE_POS_B0) begin
			r = pos[7:0];
		end else if (addr == SCR_OFF_CAPTURE_POS_B1) begin
			r = pos[15:8];
		end else if (addr == SCR_OFF_CAPTURE_POS_B2) begin
			r = pos[23:16];
		end
		return r;
	endfunction

	always_comb begin
		next_st = st;
		next_st.rd_valid = i_rd_en;
		if (i_rd_en) begin
			next_st.rdata = read_mux(i_addr, ctl0.q, ctl1.q, ctl2.q, st.pos); // [RULE18]
		end
		// status comes only from the detector, never from the write path
		if (i_pos_valid) begin
			next_st.pos = i_pos_status; // [RULE17] [RULE19]
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			st.pos <= SCR_RST_CAPTURE_POS;
			st.rdata <= SCR_RDATA_UNMAPPED;
			st.rd_valid <= 1'b0;
		end else if (i_ce) begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_rd_valid = st.rd_valid;
	assign o_sync_processor_enable = ctl0.q[SCR_BIT_PROCESSOR_EN]; // [RULE2]
	assign o_sync_receiver_enable = ctl0.q[SCR_BIT_RECEIVER_EN]; // [RULE4]
	assign o_window_fine_step = ctl0.q[SCR_BIT_FINE_STEP]; // [RULE5]
	assign o_sync_delay_select = ctl0.q[SCR_SEL_LSB +: SCR_SEL_W]; // [RULE7]
	assign o_sync_polarity_invert = ctl1.q[SCR_BIT_POL_INVERT]; // [RULE9]
	assign o_clock_input_pecl_mode = ctl1.q[SCR_BIT_CLOCK_PECL]; // [RULE10]
	assign o_sync_input_pecl_mode = ctl1.q[SCR_BIT_SYNC_PECL]; // [RULE11]
	assign o_analog_supply_quiet_enable = ctl2.q[SCR_BIT_ANALOG_QUIET]; // [RULE12]
	assign o_clock_supply_quiet_enable = ctl2.q[SCR_BIT_CLOCK_QUIET]; // [RULE13]

	// checks on the register behaviour
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);

	a_proc_enable_write: assert property ( // [RULE2]
		i_ce && i_wr_en && hit_ctl0 |=>
			o_sync_processor_enable == $past(i_wdata[SCR_BIT_PROCESSOR_EN]))
		else $error("processor enable does not follow write");

	a_recv_enable_write: assert property ( // [RULE4]
		i_ce && i_wr_en && hit_ctl0 |=>
			o_sync_receiver_enable == $past(i_wdata[SCR_BIT_RECEIVER_EN]))
		else $error("receiver enable does not follow write");

	a_fine_step_write: assert property ( // [RULE5]
		i_ce && i_wr_en && hit_ctl0 ##1 !i_wr_en [*2] |->
			o_window_fine_step == $past(i_wdata[SCR_BIT_FINE_STEP], 2))
		else $error("fine step did not hold the written value");

	a_delay_select_read: assert property ( // [RULE7]
		i_ce && i_wr_en && hit_ctl0 ##1 i_ce && i_rd_en && hit_ctl0 && !i_wr_en |=>
			o_rd_valid && o_rdata[3:0] == o_sync_delay_select &&
			o_sync_delay_select == $past(i_wdata[3:0], 2))
		else $error("delay select readback mismatch");

	a_polarity_write: assert property ( // [RULE9]
		i_ce && i_wr_en && hit_ctl1 |=>
			o_sync_polarity_invert == $past(i_wdata[SCR_BIT_POL_INVERT]))
		else $error("polarity invert does not follow write");

	a_clock_pecl_write: assert property ( // [RULE10]
		i_ce && i_wr_en && hit_ctl1 |=>
			o_clock_input_pecl_mode == $past(i_wdata[SCR_BIT_CLOCK_PECL]) &&
			$stable(o_sync_processor_enable))
		else $error("clock input mode wrong or other register disturbed");

	a_sync_pecl_write: assert property ( // [RULE11]
		i_ce && i_wr_en && hit_ctl1 |=>
			o_sync_input_pecl_mode == $past(i_wdata[SCR_BIT_SYNC_PECL]))
		else $error("sync input mode does not follow write");

	a_analog_quiet_write: assert property ( // [RULE12]
		i_ce && i_wr_en && hit_ctl2 |=>
			o_analog_supply_quiet_enable == $past(i_wdata[SCR_BIT_ANALOG_QUIET]))
		else $error("analog suppression does not follow write");

	a_clock_quiet_write: assert property ( // [RULE13]
		i_ce && i_wr_en && hit_ctl2 |=>
			o_clock_supply_quiet_enable == $past(i_wdata[SCR_BIT_CLOCK_QUIET]) &&
			$stable(o_sync_polarity_invert))
		else $error("clock suppression wrong or other register disturbed");

	a_ctl0_reset_read: assert property (disable iff (1'b0) // [RULE14]
		$past(i_rst) && !i_rst && i_ce && i_rd_en && hit_ctl0 && !i_wr_en |=>
			o_rd_valid && o_rdata == SCR_RST_CLOCK_CONTROL_0)
		else $error("clock_control_0 not 0x80 after reset");

	a_ctl1_reset_value: assert property (disable iff (1'b0) // [RULE15]
		$past(i_rst) |-> ctl1.q == SCR_RST_CLOCK_CONTROL_1 && !o_sync_polarity_invert &&
			!o_clock_input_pecl_mode && !o_sync_input_pecl_mode)
		else $error("clock_control_1 not 0x00 after reset");

	a_ctl2_reset_value: assert property (disable iff (1'b0) // [RULE16]
		$past(i_rst) |-> ctl2.q == SCR_RST_CLOCK_CONTROL_2 && !o_analog_supply_quiet_enable &&
			!o_clock_supply_quiet_enable)
		else $error("clock_control_2 not 0x10 after reset");

	a_pos_from_detector: assert property ( // [RULE17]
		i_ce && i_pos_valid ##1 i_ce && i_rd_en && !i_wr_en &&
			i_addr == SCR_OFF_CAPTURE_POS_B0 |=>
			o_rdata == $past(i_pos_status[7:0], 2))
		else $error("capture low byte not taken from detector");

	a_pos_top_byte: assert property ( // [RULE18]
		i_ce && i_rd_en && i_addr == SCR_OFF_CAPTURE_POS_B2 |=>
			o_rd_valid && o_rdata == $past(st.pos[23:16]))
		else $error("capture top byte readback mismatch");

	a_pos_write_ignored: assert property ( // [RULE19]
		i_ce && i_wr_en && hit_pos && !i_pos_valid |=>
			$stable(st.pos) && $stable(ctl0.q) && $stable(ctl1.q) && $stable(ctl2.q))
		else $error("write to capture status disturbed state");

	a_freeze_on_ce_low: assert property (
		!i_ce |=> $stable(st) && $stable(ctl0.q) && $stable(ctl1.q) && $stable(ctl2.q))
		else $error("state moved while clock enable was low");

	a_unmapped_read: assert property (
		i_ce && i_rd_en && !hit_ctl0 && !hit_ctl1 && !hit_ctl2 && !hit_pos |=>
			o_rd_valid && o_rdata == SCR_RDATA_UNMAPPED)
		else $error("unmapped read did not return zero");

	a_ctl0_read_fields: assert property ( // [RULE2] [RULE4] [RULE5]
		i_ce && i_rd_en && hit_ctl0 |=>
			o_rdata[SCR_BIT_PROCESSOR_EN] == $past(o_sync_processor_enable) &&
			o_rdata[SCR_BIT_RECEIVER_EN] == $past(o_sync_receiver_enable) &&
			o_rdata[SCR_BIT_FINE_STEP] == $past(o_window_fine_step))
		else $error("clock_control_0 read does not match its controls");

	a_ctl1_read_fields: assert property ( // [RULE9] [RULE10] [RULE11]
		i_ce && i_rd_en && hit_ctl1 |=>
			o_rdata[SCR_BIT_CLOCK_PECL] == $past(o_clock_input_pecl_mode) &&
			o_rdata[SCR_BIT_SYNC_PECL] == $past(o_sync_input_pecl_mode) &&
			o_rdata[SCR_BIT_POL_INVERT] == $past(o_sync_polarity_invert))
		else $error("clock_control_1 read does not match its controls");

	a_ctl2_read_fields: assert property ( // [RULE12] [RULE13]
		i_ce && i_rd_en && hit_ctl2 |=>
			o_rdata[SCR_BIT_ANALOG_QUIET] == $past(o_analog_supply_quiet_enable) &&
			o_rdata[SCR_BIT_CLOCK_QUIET] == $past(o_clock_supply_quiet_enable))
		else $error("clock_control_2 read does not match its controls");

	a_delay_select_write: assert property ( // [RULE7]
		i_ce && i_wr_en && hit_ctl0 |=>
			o_sync_delay_select == $past(i_wdata[SCR_SEL_LSB +: SCR_SEL_W]))
		else $error("delay select does not follow write");

	a_read_answered: assert property (
		i_ce && i_rd_en |=> o_rd_valid)
		else $error("accepted read gave no valid strobe");

	a_rd_valid_idle: assert property (
		i_ce && !i_rd_en |=> !o_rd_valid && $stable(o_rdata))
		else $error("read data moved or valid raised without a read");

	a_pos_holds: assert property ( // [RULE17]
		i_ce && !i_pos_valid |=> $stable(st.pos))
		else $error("capture status changed without a detector strobe");

	a_pos_mid_byte: assert property ( // [RULE18]
		i_ce && i_rd_en && i_addr == SCR_OFF_CAPTURE_POS_B1 |=>
			o_rd_valid && o_rdata == $past(st.pos[15:8]))
		else $error("capture middle byte readback mismatch");

	a_unmapped_write_ignored: assert property ( // [RULE19]
		i_ce && i_wr_en && !hit_ctl0 && !hit_ctl1 && !hit_ctl2 |=>
			$stable(ctl0.q) && $stable(ctl1.q) && $stable(ctl2.q))
		else $error("write outside the control bytes changed a control byte");

	a_reset_outputs_clear: assert property (disable iff (1'b0) // [RULE2] [RULE4] [RULE7]
		$past(i_rst) |-> !o_sync_processor_enable && !o_sync_receiver_enable &&
			!o_window_fine_step && o_sync_delay_select == 4'h0 && !o_rd_valid &&
			o_rdata == SCR_RDATA_UNMAPPED)
		else $error("outputs not cleared after reset");

	c_enable_sequence: cover property (
		o_sync_receiver_enable && !o_sync_processor_enable ##[1:20] o_sync_processor_enable);

	c_status_then_select: cover property (
		i_ce && i_rd_en && hit_pos ##[1:20] i_ce && i_wr_en && hit_ctl0);

	c_fine_step_on: cover property (i_ce && i_wr_en && hit_ctl0 && i_wdata[SCR_BIT_FINE_STEP]);

	c_write_then_read: cover property (
		i_ce && i_wr_en && hit_ctl0 ##1 i_ce && i_rd_en && hit_ctl0);

	c_pos_write_attempt: cover property (i_ce && i_wr_en && hit_pos);

endmodule

// ==== verif/scr_testbench.sv ====
// Purpose: self-checking bench for the sync and clock control register group
// Assumes: inputs change at the falling edge, reads answer one cycle later on o_rd_valid
// Notes: a shadow copy of the three control bytes and the capture status gives expectations
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import scr_pkg::*;
	logic i_core_clk, i_rst, i_ce, i_wr_en, i_rd_en, i_pos_valid;
	scr_addr_t i_addr;
	scr_byte_t i_wdata;
	logic [23:0] i_pos_status, pos;
	logic [7:0] o_rdata;
	logic o_rd_valid, o_sync_processor_enable, o_sync_receiver_enable, o_window_fine_step;
	logic [3:0] o_sync_delay_select;
	logic o_sync_polarity_invert, o_clock_input_pecl_mode, o_sync_input_pecl_mode;
	logic o_analog_supply_quiet_enable, o_clock_supply_quiet_enable;
	logic [11:0] ctl_out;
	scr_byte_t c0, c1, c2;
	int err_total, cmp_count, i;

	scr_clock_control_regs u_scr_clock_control_regs (.i_core_clk(i_core_clk), .i_rst(i_rst),
		.i_ce(i_ce), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_pos_valid(i_pos_valid), .i_pos_status(i_pos_status), .o_rdata(o_rdata),
		.o_rd_valid(o_rd_valid), .o_sync_processor_enable(o_sync_processor_enable),
		.o_sync_receiver_enable(o_sync_receiver_enable), .o_window_fine_step(o_window_fine_step),
		.o_sync_delay_select(o_sync_delay_select), .o_sync_polarity_invert(o_sync_polarity_invert),
		.o_clock_input_pecl_mode(o_clock_input_pecl_mode),
		.o_sync_input_pecl_mode(o_sync_input_pecl_mode),
		.o_analog_supply_quiet_enable(o_analog_supply_quiet_enable),
		.o_clock_supply_quiet_enable(o_clock_supply_quiet_enable));

	assign ctl_out = {o_sync_processor_enable, o_sync_receiver_enable, o_window_fine_step,
		o_sync_delay_select, o_sync_polarity_invert, o_clock_input_pecl_mode,
		o_sync_input_pecl_mode, o_analog_supply_quiet_enable, o_clock_supply_quiet_enable};

	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end

	task automatic end_sim();
		if (err_total == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// control outputs against the shadow bytes
	task automatic chk_out();
		logic [11:0] exp;
		exp = {c0[6:0], c1[0], c1[2], c1[1], c2[2], c2[0]};
		cmp_count++;
		if (ctl_out !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, ctl_out, exp);
		end
	endtask

	task automatic wr(input scr_addr_t a, input scr_byte_t d);
		@(negedge i_core_clk);
		i_wr_en = 1'b1;
		i_addr = a;
		i_wdata = d;
		if (i_ce) begin
			case (a)
				SCR_OFF_CLOCK_CONTROL_0: c0 = d;
				SCR_OFF_CLOCK_CONTROL_1: c1 = d;
				SCR_OFF_CLOCK_CONTROL_2: c2 = d;
				default: ;
			endcase
		end
		@(negedge i_core_clk);
		i_wr_en = 1'b0;
	endtask

	task automatic rd(input scr_addr_t a, input scr_byte_t e);
		int n;
		@(negedge i_core_clk);
		i_rd_en = 1'b1;
		i_addr = a;
		@(negedge i_core_clk);
		i_rd_en = 1'b0;
		n = 0;
		while (o_rd_valid !== 1'b1 && n < 4) begin
			@(negedge i_core_clk);
			n++;
		end
		if (n == 4) begin
			err_total++;
			end_sim();
		end else begin
			chk8(o_rdata, e);
		end
	endtask

	task automatic load_pos(input logic [23:0] v);
		@(negedge i_core_clk);
		i_pos_valid = 1'b1;
		i_pos_status = v;
		if (i_ce) pos = v;
		@(negedge i_core_clk);
		i_pos_valid = 1'b0;
		i_pos_status = ~v;
	endtask

	task automatic do_reset();
		i_rst = 1'b1;
		repeat (2) @(negedge i_core_clk);
		c0 = SCR_RST_CLOCK_CONTROL_0;
		c1 = SCR_RST_CLOCK_CONTROL_1;
		c2 = SCR_RST_CLOCK_CONTROL_2;
		pos = SCR_RST_CAPTURE_POS;
		// first read goes out in the very cycle reset is released
		i_rst = 1'b0;
		i_rd_en = 1'b1;
		i_addr = SCR_OFF_CLOCK_CONTROL_0;
		@(negedge i_core_clk);
		i_rd_en = 1'b0;
		chk8(o_rdata, c0);
	endtask

	initial begin
		{i_ce, i_wr_en, i_rd_en, i_pos_valid} = 4'b1000;
		i_addr = '0;
		i_wdata = '0;
		i_pos_status = '0;
		err_total = 0;
		cmp_count = 0;
		do_reset();
		chk_out();
		rd(SCR_OFF_CLOCK_CONTROL_0, 8'h80);
		rd(SCR_OFF_CLOCK_CONTROL_1, 8'h00);
		rd(SCR_OFF_CLOCK_CONTROL_2, 8'h10);
		rd(SCR_OFF_CAPTURE_POS_B2, 8'h00);
		wr(SCR_OFF_CLOCK_CONTROL_0, 8'ha0);
		chk_out();
		wr(SCR_OFF_CLOCK_CONTROL_0, 8'he0);
		chk_out();
		for (i = 0; i < 16; i++) begin
			wr(SCR_OFF_CLOCK_CONTROL_0, 8'he0 | (i[0] << 4) | i[7:0]);
			chk_out();
		end
		rd(SCR_OFF_CLOCK_CONTROL_0, 8'hff);
		for (i = 0; i < 3; i++) begin
			wr(SCR_OFF_CLOCK_CONTROL_1, 8'h01 << i);
			chk_out();
			rd(SCR_OFF_CLOCK_CONTROL_1, c1);
		end
		wr(SCR_OFF_CLOCK_CONTROL_2, 8'h14);
		chk_out();
		wr(SCR_OFF_CLOCK_CONTROL_2, 8'h11);
		chk_out();
		rd(SCR_OFF_CLOCK_CONTROL_2, 8'h11);
		load_pos(24'ha5c381);
		rd(SCR_OFF_CAPTURE_POS_B0, 8'h81);
		rd(SCR_OFF_CAPTURE_POS_B1, 8'hc3);
		rd(SCR_OFF_CAPTURE_POS_B2, 8'ha5);
		// delay tap picked from the status just read, read back straight behind the write
		@(negedge i_core_clk);
		i_wr_en = 1'b1;
		i_addr = SCR_OFF_CLOCK_CONTROL_0;
		i_wdata = 8'hf5;
		c0 = 8'hf5;
		@(negedge i_core_clk);
		{i_wr_en, i_rd_en} = 2'b01;
		@(negedge i_core_clk);
		i_rd_en = 1'b0;
		chk8(o_rdata, c0);
		chk_out();
		for (i = 0; i < 4; i++) wr(SCR_OFF_CAPTURE_POS_B0 + i[14:0], 8'hff);
		chk_out();
		rd(SCR_OFF_CAPTURE_POS_B0, 8'h81);
		rd(SCR_OFF_CAPTURE_POS_B2, 8'ha5);
		rd(SCR_OFF_CLOCK_CONTROL_0, c0);
		rd(15'h0030, SCR_RDATA_UNMAPPED);
		rd(15'h7fff, SCR_RDATA_UNMAPPED);
		i_ce = 1'b0;
		wr(SCR_OFF_CLOCK_CONTROL_0, 8'h8f);
		load_pos(24'h123456);
		i_ce = 1'b1;
		chk_out();
		rd(SCR_OFF_CAPTURE_POS_B1, pos[15:8]);
		// read and write together, then a read straight behind it
		@(negedge i_core_clk);
		{i_rd_en, i_wr_en} = 2'b11;
		i_addr = SCR_OFF_CLOCK_CONTROL_1;
		i_wdata = 8'h05;
		@(negedge i_core_clk);
		i_wr_en = 1'b0;
		i_addr = SCR_OFF_CLOCK_CONTROL_2;
		chk8(o_rdata, c1);
		c1 = 8'h05;
		@(negedge i_core_clk);
		i_rd_en = 1'b0;
		chk8(o_rdata, c2);
		chk_out();
		@(negedge i_core_clk);
		chk8({7'h00, o_rd_valid}, 8'h00);
		// detector load followed at once by a read of the low byte
		@(negedge i_core_clk);
		i_pos_valid = 1'b1;
		i_pos_status = 24'h5a3c96;
		pos = 24'h5a3c96;
		@(negedge i_core_clk);
		i_pos_valid = 1'b0;
		i_rd_en = 1'b1;
		i_addr = SCR_OFF_CAPTURE_POS_B0;
		@(negedge i_core_clk);
		i_rd_en = 1'b0;
		chk8(o_rdata, pos[7:0]);
		do_reset();
		chk_out();
		rd(SCR_OFF_CLOCK_CONTROL_0, 8'h80);
		rd(SCR_OFF_CLOCK_CONTROL_2, 8'h10);
		rd(SCR_OFF_CAPTURE_POS_B0, 8'h00);
		end_sim();
	end
endmodule
